// ### hdl/pfhu_fault_unit.v
// Fault detection, classification, escalation and lockup logic
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pfhu_map.vh"
// Notes on behaviour
// - Bus error on fetch, vector, data faults
// - Undefined opcode or state change faults
// - No-execute fetch gives protection fault always
// - Vector read bus error is hard fault
// - Escalation takes hard fault, sets flag
// - Protection mismatches flagged per access kind
// - Bus errors flagged per access kind
// - Usage faults each carry own flag
// - Bad state: foreign set or continuation
// - Class priorities and enables are configurable
// - Same-kind fault in handler escalates
// - Equal or lower priority fault escalates
// - Disabled class handler fault escalates
// - Push error entering bus handler not escalated
// - Hard fault preempted only by reset, NMI
// - Data protection and precise bus faults record address outside lockup; both in one cycle store only the protection one
// - Hard fault in NMI/hard handler locks up
// - Lockup left by reset, NMI or halt
// - NMI cannot release lockup entered from NMI
// - Equal priority exception escalates; only a kept push error pends
module pfhu_fault_unit #(
  parameter AW = 32,
  parameter PW = 8
) (
  input  wire          CLOCK_IN,
  input  wire          RESETN_IN,
  input  wire [3:0]    REG_ADDR_IN,
  input  wire [31:0]   REG_WDATA_IN,
  input  wire          REG_WR_IN,
  input  wire          REG_RD_IN,
  output reg  [31:0]   REG_RDATA_OUT,
  input  wire          FETCH_BUS_ERR_IN,
  input  wire          VECTOR_BUS_ERR_IN,
  input  wire          DATA_BUS_ERR_IN,
  input  wire          DATA_ERR_DEFERRED_IN,
  input  wire          PUSH_BUS_ERR_IN,
  input  wire          POP_BUS_ERR_IN,
  input  wire          NO_EXECUTE_ATTRIBUTE_IN,
  input  wire          FETCH_PROT_ERR_IN,
  input  wire          DATA_PROT_ERR_IN,
  input  wire          PUSH_PROT_ERR_IN,
  input  wire          POP_PROT_ERR_IN,
  input  wire          COPROC_ACCESS_IN,
  input  wire          UNKNOWN_OPCODE_IN,
  input  wire          FOREIGN_SET_IN,
  input  wire          INTERRUPTED_MULTIPLE_STATE_IN,
  input  wire          NOT_MULTIPLE_TARGET_IN,
  input  wire          BAD_RETURN_CODE_IN,
  input  wire          MISALIGNED_ACCESS_IN,
  input  wire          ZERO_DIVISOR_IN,
  input  wire [AW-1:0] FAULT_ADDR_IN,
  input  wire          ACTIVE_VALID_IN,
  input  wire [PW-1:0] ACTIVE_PRIO_IN,
  input  wire [1:0]    ACTIVE_CLASS_IN,
  input  wire          ACTIVE_IS_FAULT_IN,
  input  wire          ACTIVE_IS_NMI_IN,
  input  wire          ACTIVE_IS_HARD_IN,
  input  wire          ENTERING_BUS_HANDLER_IN,
  input  wire          NMI_IN,
  input  wire          DEBUG_HALT_IN,
  output reg           FAULT_TAKE_OUT,
  output reg  [1:0]    FAULT_CLASS_OUT,
  output reg           FAULT_PEND_OUT,
  output reg           LOCKUP_OUT
);
  // ***************************************************************
  // Declarations
  // ***************************************************************
  localparam ST_RUN     = 2'h0;
  localparam ST_LOCK    = 2'h1;
  localparam ST_LOCKNMI = 2'h2;
  reg [1:0]    hard_fault_status_reg;
  reg [4:0]    protection_fault_status_reg;
  reg [5:0]    bus_error_status_reg;
  reg [5:0]    usage_error_status_reg;
  reg [3*PW-1:0] handler_priority_cfg_reg;
  reg [2:0]    handler_enable_ctrl_reg;
  reg [1:0]    state_reg;
  reg [1:0]    state_next;
  reg          rd_pending_reg;
  reg [3:0]    rd_addr_reg;
  wire [31:0]  addr_rdata;
  wire         wr_hit;
  wire [4:0]   mf_ev;
  wire [5:0]   bf_ev;
  wire [5:0]   uf_ev;
  wire         bad_state;
  wire         prot_ev;
  wire         bus_ev;
  wire         usage_ev;
  wire         table_read_bus_error_flag_ev;
  reg  [1:0]   cls;
  reg  [PW-1:0] cls_prio;
  reg          cls_en;
  reg          escalate;
  reg          push_keep;
  reg  [31:0]  rdata_reg;
  reg          hard_now;
  wire         any_fault;
  wire         lock_enter;
  wire         addr_we;
  wire         addr_wsel;

  function [PW-1:0] prio_of;
    input [1:0]      c;
    input [3*PW-1:0] cfg;
    begin
      case (c)
        `PFHU_CLS_PROT:  prio_of = cfg[PW-1:0];
        `PFHU_CLS_BUS:   prio_of = cfg[2*PW-1:PW];
        `PFHU_CLS_USAGE: prio_of = cfg[3*PW-1:2*PW];
        default:         prio_of = {PW{1'b0}};
      endcase
    end
  endfunction

  // ***************************************************************
  // Fault source classification
  // ***************************************************************
  assign table_read_bus_error_flag_ev   = VECTOR_BUS_ERR_IN;
  assign mf_ev[`PFHU_MF_FETCH] = FETCH_PROT_ERR_IN | NO_EXECUTE_ATTRIBUTE_IN;
  assign mf_ev[`PFHU_MF_DATA]  = DATA_PROT_ERR_IN;
  assign mf_ev[`PFHU_MF_PUSH]  = PUSH_PROT_ERR_IN;
  assign mf_ev[`PFHU_MF_POP]   = POP_PROT_ERR_IN;
  assign mf_ev[`PFHU_MF_ADDR_VALID] = DATA_PROT_ERR_IN;
  assign bf_ev[`PFHU_BF_PUSH]     = PUSH_BUS_ERR_IN;
  assign bf_ev[`PFHU_BF_POP]      = POP_BUS_ERR_IN;
  assign bf_ev[`PFHU_BF_PREFETCH] = FETCH_BUS_ERR_IN;
  assign bf_ev[`PFHU_BF_PRECISE]  = DATA_BUS_ERR_IN & ~DATA_ERR_DEFERRED_IN;
  assign bf_ev[`PFHU_BF_DEFERRED] = DATA_BUS_ERR_IN & DATA_ERR_DEFERRED_IN;
  assign bf_ev[`PFHU_BF_ADDR_VALID] = bf_ev[`PFHU_BF_PRECISE];
  assign bad_state = FOREIGN_SET_IN |
                     (INTERRUPTED_MULTIPLE_STATE_IN & NOT_MULTIPLE_TARGET_IN);
  assign uf_ev[`PFHU_UF_COPROC]     = COPROC_ACCESS_IN;
  assign uf_ev[`PFHU_UF_UNKNOWN]    = UNKNOWN_OPCODE_IN;
  assign uf_ev[`PFHU_UF_BAD_STATE]  = bad_state;
  assign uf_ev[`PFHU_UF_BAD_RETURN] = BAD_RETURN_CODE_IN;
  assign uf_ev[`PFHU_UF_MISALIGN]   = MISALIGNED_ACCESS_IN;
  assign uf_ev[`PFHU_UF_ZERO_DIV]   = ZERO_DIVISOR_IN;
  assign prot_ev  = |mf_ev[3:0];
  assign bus_ev   = |bf_ev[4:0];
  assign usage_ev = |uf_ev;
  assign any_fault = table_read_bus_error_flag_ev | prot_ev | bus_ev | usage_ev;

  // ***************************************************************
  // Escalation decision
  // ***************************************************************
  always @* begin
    if (prot_ev) begin
      cls = `PFHU_CLS_PROT;
    end else if (bus_ev) begin
      cls = `PFHU_CLS_BUS;
    end else begin
      cls = `PFHU_CLS_USAGE;
    end
    cls_prio = prio_of(cls, handler_priority_cfg_reg);
    cls_en   = handler_enable_ctrl_reg[cls];
    escalate = 1'b0;
    push_keep = bus_ev && !prot_ev && PUSH_BUS_ERR_IN && ENTERING_BUS_HANDLER_IN;
    if (!cls_en) begin
      escalate = 1'b1;
    end
    if (ACTIVE_VALID_IN && ACTIVE_IS_FAULT_IN && ACTIVE_CLASS_IN == cls) begin
      escalate = 1'b1;
    end
    if (ACTIVE_VALID_IN && cls_prio >= ACTIVE_PRIO_IN) begin
      escalate = 1'b1;
    end
    if (push_keep) begin
      escalate = 1'b0;
    end
    hard_now = table_read_bus_error_flag_ev | ((prot_ev | bus_ev | usage_ev) & escalate);
  end

  // Hard fault inside NMI or hard handler cannot preempt and locks up
  assign lock_enter = hard_now & ACTIVE_VALID_IN &
                      (ACTIVE_IS_NMI_IN | ACTIVE_IS_HARD_IN);

  // ***************************************************************
  // Lockup state machine
  // ***************************************************************
  always @* begin
    case (state_reg)
      ST_RUN: begin
        if (lock_enter && ACTIVE_IS_NMI_IN) begin
          state_next = ST_LOCKNMI;
        end else if (lock_enter) begin
          state_next = ST_LOCK;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_LOCK: begin
        if (NMI_IN || DEBUG_HALT_IN) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_LOCK;
        end
      end
      ST_LOCKNMI: begin
        if (DEBUG_HALT_IN) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_LOCKNMI;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  // ***************************************************************
  // Register bus
  // ***************************************************************
  assign wr_hit = REG_WR_IN;
  assign addr_we   = (prot_ev & DATA_PROT_ERR_IN) | bf_ev[`PFHU_BF_PRECISE];
  assign addr_wsel = ~(prot_ev & DATA_PROT_ERR_IN);

  pfhu_addr_store #(
    .AW          (AW)
  ) u_addr_store (
    .clk_in      (CLOCK_IN),
    .resetn_in   (RESETN_IN),
    .wr_en_in    (addr_we & (state_reg == ST_RUN)),
    .wr_sel_in   (addr_wsel),
    .wr_data_in  (FAULT_ADDR_IN),
    .rd_sel_in   (REG_ADDR_IN == `PFHU_ADDR_BUS_ADDR),
    .rd_data_out (addr_rdata)
  );

  // Address words come from the store's own register
  always @* begin
    if (rd_pending_reg && (rd_addr_reg == `PFHU_ADDR_PROT_ADDR ||
                           rd_addr_reg == `PFHU_ADDR_BUS_ADDR)) begin
      REG_RDATA_OUT = addr_rdata;
    end else begin
      REG_RDATA_OUT = rdata_reg;
    end
  end

  // ***************************************************************
  // Status and control registers
  // ***************************************************************
  always @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      hard_fault_status_reg       <= 2'h0;
      protection_fault_status_reg <= 5'h00;
      bus_error_status_reg        <= 6'h00;
      usage_error_status_reg      <= 6'h00;
      handler_priority_cfg_reg    <= `PFHU_PRIO_RESET;
      handler_enable_ctrl_reg     <= `PFHU_ENABLE_RESET;
      state_reg                   <= ST_RUN;
      rd_pending_reg              <= 1'b0;
      rd_addr_reg                 <= 4'h0;
      rdata_reg                   <= 32'h00000000;
      FAULT_TAKE_OUT              <= 1'b0;
      FAULT_CLASS_OUT             <= 2'h0;
      FAULT_PEND_OUT              <= 1'b0;
      LOCKUP_OUT                  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      LOCKUP_OUT <= (state_next != ST_RUN);
      // Write-one-to-clear, a new event wins over the clear
      hard_fault_status_reg <= (hard_fault_status_reg &
          ~((wr_hit && REG_ADDR_IN == `PFHU_ADDR_HARD_STAT) ? REG_WDATA_IN[1:0] : 2'h0)) |
          {hard_now & ~table_read_bus_error_flag_ev, table_read_bus_error_flag_ev};
      protection_fault_status_reg <= (protection_fault_status_reg &
          ~((wr_hit && REG_ADDR_IN == `PFHU_ADDR_PROT_STAT) ? REG_WDATA_IN[4:0] : 5'h00)) |
          mf_ev;
      bus_error_status_reg <= (bus_error_status_reg &
          ~((wr_hit && REG_ADDR_IN == `PFHU_ADDR_BUS_STAT) ? REG_WDATA_IN[5:0] : 6'h00)) |
          bf_ev;
      usage_error_status_reg <= (usage_error_status_reg &
          ~((wr_hit && REG_ADDR_IN == `PFHU_ADDR_USAGE_STAT) ? REG_WDATA_IN[5:0] : 6'h00)) |
          uf_ev;
      if (wr_hit && REG_ADDR_IN == `PFHU_ADDR_PRIO_CFG) begin
        handler_priority_cfg_reg <= REG_WDATA_IN[3*PW-1:0];
      end
      if (wr_hit && REG_ADDR_IN == `PFHU_ADDR_ENABLE_CTRL) begin
        handler_enable_ctrl_reg <= REG_WDATA_IN[2:0];
      end
      // Fault request toward the prioritiser
      FAULT_TAKE_OUT  <= any_fault & (state_reg == ST_RUN) & ~lock_enter &
                         (hard_now | push_keep | ~ACTIVE_VALID_IN |
                          cls_prio < ACTIVE_PRIO_IN);
      FAULT_CLASS_OUT <= hard_now ? `PFHU_CLS_HARD : cls;
      FAULT_PEND_OUT  <= any_fault & ~hard_now & ACTIVE_VALID_IN &
                         (cls_prio == ACTIVE_PRIO_IN) & ~escalate;
      rd_pending_reg <= REG_RD_IN;
      rd_addr_reg    <= REG_ADDR_IN;
      if (REG_RD_IN) begin
        case (REG_ADDR_IN)
          `PFHU_ADDR_HARD_STAT:   rdata_reg <= {30'h0, hard_fault_status_reg};
          `PFHU_ADDR_PROT_STAT:   rdata_reg <= {27'h0, protection_fault_status_reg};
          `PFHU_ADDR_BUS_STAT:    rdata_reg <= {26'h0, bus_error_status_reg};
          `PFHU_ADDR_USAGE_STAT:  rdata_reg <= {26'h0, usage_error_status_reg};
          `PFHU_ADDR_PRIO_CFG:    rdata_reg <= {{(32-3*PW){1'b0}}, handler_priority_cfg_reg};
          `PFHU_ADDR_ENABLE_CTRL: rdata_reg <= {29'h0, handler_enable_ctrl_reg};
          `PFHU_ADDR_STATE:       rdata_reg <= {30'h0, state_reg};
          default:                rdata_reg <= 32'h00000000;
        endcase
      end else begin
        rdata_reg <= 32'h00000000;
      end
    end
  end

endmodule // pfhu_fault_unit

// ### hdl/pfhu_map.vh
// Register offsets, field positions and reset values of the fault handling unit
`ifndef PFHU_MAP_VH
`define PFHU_MAP_VH
// ***************************************************************
// Register offsets
// ***************************************************************
`define PFHU_ADDR_HARD_STAT   4'h0
`define PFHU_ADDR_PROT_STAT   4'h1
`define PFHU_ADDR_BUS_STAT    4'h2
`define PFHU_ADDR_USAGE_STAT  4'h3
`define PFHU_ADDR_PROT_ADDR   4'h4
`define PFHU_ADDR_BUS_ADDR    4'h5
`define PFHU_ADDR_PRIO_CFG    4'h6
`define PFHU_ADDR_ENABLE_CTRL 4'h7
`define PFHU_ADDR_STATE       4'h8
// ***************************************************************
// Hard fault status fields
// ***************************************************************
`define PFHU_HF_TABLE_READ_BUS_ERROR_FLAG          0
`define PFHU_HF_ESC           1
// ***************************************************************
// Protection fault status fields
// ***************************************************************
`define PFHU_MF_FETCH         0
`define PFHU_MF_DATA          1
`define PFHU_MF_PUSH          2
`define PFHU_MF_POP           3
`define PFHU_MF_ADDR_VALID    4
// ***************************************************************
// Bus error status fields
// ***************************************************************
`define PFHU_BF_PUSH          0
`define PFHU_BF_POP           1
`define PFHU_BF_PREFETCH      2
`define PFHU_BF_PRECISE       3
`define PFHU_BF_DEFERRED      4
`define PFHU_BF_ADDR_VALID    5
// ***************************************************************
// Usage fault status fields
// ***************************************************************
`define PFHU_UF_COPROC        0
`define PFHU_UF_UNKNOWN       1
`define PFHU_UF_BAD_STATE     2
`define PFHU_UF_BAD_RETURN    3
`define PFHU_UF_MISALIGN      4
`define PFHU_UF_ZERO_DIV      5
// ***************************************************************
// Fault classes and reset values
// ***************************************************************
`define PFHU_CLS_PROT         2'h0
`define PFHU_CLS_BUS          2'h1
`define PFHU_CLS_USAGE        2'h2
`define PFHU_CLS_HARD         2'h3
`define PFHU_PRIO_RESET       24'h000000
`define PFHU_ENABLE_RESET     3'h0
`endif

// ### hdl/pfhu_addr_store.v
// Two-word fault address memory with registered read data
`timescale 1ns/1ps
module pfhu_addr_store #(
  parameter AW = 32
) (
  input  wire          clk_in,
  input  wire          resetn_in,
  input  wire          wr_en_in,
  input  wire          wr_sel_in,
  input  wire [AW-1:0] wr_data_in,
  input  wire          rd_sel_in,
  output reg  [AW-1:0] rd_data_out
);
  reg [AW-1:0] mem_reg [0:1];
  // ***************************************************************
  // Storage
  // ***************************************************************
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_reg[0]  <= {AW{1'b0}};
      mem_reg[1]  <= {AW{1'b0}};
      rd_data_out <= {AW{1'b0}};
    end else begin
      if (wr_en_in) begin
        mem_reg[wr_sel_in] <= wr_data_in;
      end
      rd_data_out <= mem_reg[rd_sel_in];
    end
  end
endmodule // pfhu_addr_store

// ### bench/pfhu_pipe_model.sv
// Pipeline, bus and protection unit model that issues fault events
`timescale 1ns/1ps
module pfhu_pipe_model (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire        req_in,
  input  wire [18:0] req_ev_in,
  input  wire [31:0] req_addr_in,
  output reg  [18:0] ev_out,
  output reg  [31:0] addr_out
);
  // ***************************************************************
  // Events stand one cycle, address is scrambled outside it
  // ***************************************************************
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ev_out   <= 19'h00000;
      addr_out <= 32'h00000000;
    end else begin
      ev_out   <= req_in ? req_ev_in : 19'h00000;
      addr_out <= req_in ? req_addr_in : ~addr_out;
    end
  end
endmodule // pfhu_pipe_model

// ### bench/pfhu_fault_unit_properties.sv
// Concurrent checks on the fault unit ports
`timescale 1ns/1ps
`include "pfhu_map.vh"
module pfhu_fault_checker (
  input wire        CLOCK_IN,
  input wire        RESETN_IN,
  input wire        REG_RD_IN,
  input wire [31:0] REG_RDATA_OUT,
  input wire        FETCH_BUS_ERR_IN,
  input wire        VECTOR_BUS_ERR_IN,
  input wire        PUSH_BUS_ERR_IN,
  input wire        NO_EXECUTE_ATTRIBUTE_IN,
  input wire        UNKNOWN_OPCODE_IN,
  input wire        ZERO_DIVISOR_IN,
  input wire        ACTIVE_VALID_IN,
  input wire        ACTIVE_IS_NMI_IN,
  input wire        ACTIVE_IS_HARD_IN,
  input wire        ENTERING_BUS_HANDLER_IN,
  input wire        NMI_IN,
  input wire        DEBUG_HALT_IN,
  input wire        FAULT_TAKE_OUT,
  input wire [1:0]  FAULT_CLASS_OUT,
  input wire        LOCKUP_OUT
);
  // ***************************************************************
  // Helper state and sequences
  // ***************************************************************
  reg  nmi_lock_reg;
  wire critical = ACTIVE_VALID_IN && (ACTIVE_IS_NMI_IN || ACTIVE_IS_HARD_IN);
  always @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) nmi_lock_reg <= 1'b0;
    else if (!LOCKUP_OUT) nmi_lock_reg <= ACTIVE_IS_NMI_IN;
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_hard_in_critical;
    VECTOR_BUS_ERR_IN && critical && !LOCKUP_OUT && !NMI_IN && !DEBUG_HALT_IN;
  endsequence
  sequence s_settled_lock;
    LOCKUP_OUT ##1 LOCKUP_OUT;
  endsequence
  property p_rdata_idle;
    !REG_RD_IN |=> REG_RDATA_OUT == 32'h00000000;
  endproperty
  property p_fault_take;
    (UNKNOWN_OPCODE_IN || ZERO_DIVISOR_IN || FETCH_BUS_ERR_IN || NO_EXECUTE_ATTRIBUTE_IN)
      && !LOCKUP_OUT && !ACTIVE_VALID_IN |=> FAULT_TAKE_OUT;
  endproperty
  property p_table_read_bus_error_flag_hard;
    VECTOR_BUS_ERR_IN && !LOCKUP_OUT && !critical
      |=> FAULT_TAKE_OUT && FAULT_CLASS_OUT == `PFHU_CLS_HARD;
  endproperty
  property p_push_keep;
    PUSH_BUS_ERR_IN && ENTERING_BUS_HANDLER_IN && !LOCKUP_OUT && !critical
      && !VECTOR_BUS_ERR_IN |=> FAULT_TAKE_OUT && FAULT_CLASS_OUT == `PFHU_CLS_BUS;
  endproperty
  property p_lock_entry;
    s_hard_in_critical |=> LOCKUP_OUT;
  endproperty
  property p_lock_hold;
    LOCKUP_OUT && !NMI_IN && !DEBUG_HALT_IN |=> LOCKUP_OUT;
  endproperty
  property p_nmi_release;
    LOCKUP_OUT && NMI_IN && !nmi_lock_reg |=> !LOCKUP_OUT;
  endproperty
  property p_halt_release;
    LOCKUP_OUT && DEBUG_HALT_IN |=> !LOCKUP_OUT;
  endproperty
  property p_nmi_no_release;
    LOCKUP_OUT && nmi_lock_reg && !DEBUG_HALT_IN |=> LOCKUP_OUT;
  endproperty
  property p_no_take_locked;
    s_settled_lock |-> !FAULT_TAKE_OUT;
  endproperty
  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  a_fault_take: assert property (p_fault_take)
    else $error("fault event without handler take");
  a_table_read_bus_error_flag_hard: assert property (p_table_read_bus_error_flag_hard)
    else $error("vector bus error not taken as hard fault");
  a_push_keep: assert property (p_push_keep)
    else $error("push bus error on handler entry escalated");
  a_lock_entry: assert property (p_lock_entry)
    else $error("hard fault in critical handler did not lock");
  a_lock_hold: assert property (p_lock_hold)
    else $error("lockup left without release request");
  a_nmi_release: assert property (p_nmi_release)
    else $error("nmi did not release lockup");
  a_halt_release: assert property (p_halt_release)
    else $error("halt did not release lockup");
  a_nmi_no_release: assert property (p_nmi_no_release)
    else $error("nmi released lockup entered from nmi handler");
  a_no_take_locked: assert property (p_no_take_locked)
    else $error("handler taken while locked");
endmodule // pfhu_fault_checker
bind pfhu_fault_unit pfhu_fault_checker i_chk (
  .CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .FETCH_BUS_ERR_IN(FETCH_BUS_ERR_IN),
  .VECTOR_BUS_ERR_IN(VECTOR_BUS_ERR_IN), .PUSH_BUS_ERR_IN(PUSH_BUS_ERR_IN),
  .NO_EXECUTE_ATTRIBUTE_IN(NO_EXECUTE_ATTRIBUTE_IN), .UNKNOWN_OPCODE_IN(UNKNOWN_OPCODE_IN),
  .ZERO_DIVISOR_IN(ZERO_DIVISOR_IN), .ACTIVE_VALID_IN(ACTIVE_VALID_IN),
  .ACTIVE_IS_NMI_IN(ACTIVE_IS_NMI_IN), .ACTIVE_IS_HARD_IN(ACTIVE_IS_HARD_IN),
  .ENTERING_BUS_HANDLER_IN(ENTERING_BUS_HANDLER_IN), .NMI_IN(NMI_IN),
  .DEBUG_HALT_IN(DEBUG_HALT_IN), .FAULT_TAKE_OUT(FAULT_TAKE_OUT),
  .FAULT_CLASS_OUT(FAULT_CLASS_OUT), .LOCKUP_OUT(LOCKUP_OUT));

// ### bench/pfhu_fault_unit_bench.sv
// Register and fault event tests for the fault unit
`timescale 1ns/1ps
`include "pfhu_map.vh"
module pfhu_fault_unit_bench;
  logic clk = 1'b0, resetn = 1'b0, r_wr = 1'b0, r_rd = 1'b0, p_req = 1'b0;
  logic [3:0] r_addr = 4'h0;
  logic [31:0] r_wdata = 32'h0, p_addr = 32'h0, cycles = 32'h0;
  logic [18:0] p_ev = 19'h0;
  logic a_valid = 1'b0, a_fault = 1'b0, a_nmi = 1'b0, a_hard = 1'b0, a_entry = 1'b0;
  logic nmi = 1'b0, halt = 1'b0, t_take, t, t_pend;
  logic [7:0] a_prio = 8'h00, v;
  logic [1:0] a_class = 2'h0, t_cls, c;
  logic [18:0] e;
  logic [3:0] ix;
  logic [4:0] i;
  logic [33:0] tab [0:18];
  wire [31:0] r_rdata, fa;
  wire [18:0] ev;
  wire take, pend, lock;
  wire [1:0] cls;
  integer n_errors = 0, tests_run = 0;
  pfhu_pipe_model i_pipe (.clk_in(clk), .resetn_in(resetn), .req_in(p_req),
    .req_ev_in(p_ev), .req_addr_in(p_addr), .ev_out(ev), .addr_out(fa));
  pfhu_fault_unit i_dut (
    .CLOCK_IN(clk), .RESETN_IN(resetn), .REG_ADDR_IN(r_addr), .REG_WDATA_IN(r_wdata),
    .REG_WR_IN(r_wr), .REG_RD_IN(r_rd), .REG_RDATA_OUT(r_rdata),
    .FETCH_BUS_ERR_IN(ev[0]), .VECTOR_BUS_ERR_IN(ev[1]), .DATA_BUS_ERR_IN(ev[2]),
    .DATA_ERR_DEFERRED_IN(ev[3]), .PUSH_BUS_ERR_IN(ev[4]), .POP_BUS_ERR_IN(ev[5]),
    .NO_EXECUTE_ATTRIBUTE_IN(ev[6]), .FETCH_PROT_ERR_IN(ev[7]), .DATA_PROT_ERR_IN(ev[8]),
    .PUSH_PROT_ERR_IN(ev[9]), .POP_PROT_ERR_IN(ev[10]), .COPROC_ACCESS_IN(ev[11]),
    .UNKNOWN_OPCODE_IN(ev[12]), .FOREIGN_SET_IN(ev[13]),
    .INTERRUPTED_MULTIPLE_STATE_IN(ev[14]), .NOT_MULTIPLE_TARGET_IN(ev[15]),
    .BAD_RETURN_CODE_IN(ev[16]), .MISALIGNED_ACCESS_IN(ev[17]), .ZERO_DIVISOR_IN(ev[18]),
    .FAULT_ADDR_IN(fa), .ACTIVE_VALID_IN(a_valid), .ACTIVE_PRIO_IN(a_prio),
    .ACTIVE_CLASS_IN(a_class), .ACTIVE_IS_FAULT_IN(a_fault), .ACTIVE_IS_NMI_IN(a_nmi),
    .ACTIVE_IS_HARD_IN(a_hard), .ENTERING_BUS_HANDLER_IN(a_entry), .NMI_IN(nmi),
    .DEBUG_HALT_IN(halt), .FAULT_TAKE_OUT(take), .FAULT_CLASS_OUT(cls),
    .FAULT_PEND_OUT(pend), .LOCKUP_OUT(lock));
  // ***************************************************************
  // Access tasks
  // ***************************************************************
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'h00000BB8) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    r_wr <= 1'b1;
    r_addr <= a;
    r_wdata <= d;
    @(posedge clk);
    r_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    r_rd <= 1'b1;
    r_addr <= a;
    @(posedge clk);
    r_rd <= 1'b0;
    #1 chk($sformatf("reg %0h", a), x, r_rdata);
  endtask
  task automatic ctx(input logic [4:0] f, input logic [7:0] p, input logic [1:0] k);
    @(posedge clk);
    {a_valid, a_fault, a_nmi, a_hard, a_entry} <= f;
    a_prio <= p;
    a_class <= k;
  endtask
  task automatic fire(input logic [18:0] x, input logic [31:0] a);
    @(posedge clk);
    p_req <= 1'b1;
    p_ev <= x;
    p_addr <= a;
    @(posedge clk);
    p_req <= 1'b0;
    @(posedge clk);
    #1 t_take = take;
    t_cls = cls;
    t_pend = pend;
  endtask
  task automatic esc(input logic [4:0] f, input logic [7:0] p, input logic [1:0] k,
                     input logic [18:0] x, input logic [1:0] ec, input logic [31:0] hs);
    logic [3:0] j;
    ctx(f, p, k);
    fire(x, 32'h0);
    chk("take", 32'h1, {31'h0, t_take});
    chk("class", {30'h0, ec}, {30'h0, t_cls});
    chk("pend", 32'h0, {31'h0, t_pend});
    rdc(`PFHU_ADDR_HARD_STAT, hs);
    for (j = 4'h0; j < 4'h4; j++) wr(j, 32'hFFFFFFFF);
    ctx(5'h00, 8'h00, 2'h0);
  endtask
  task automatic lock_in(input logic [4:0] f, input logic [31:0] st);
    ctx(f, 8'h00, `PFHU_CLS_HARD);
    fire(19'h00002, 32'h0);
    chk("lockup", 32'h1, {31'h0, lock});
    rdc(`PFHU_ADDR_STATE, st);
  endtask
  task automatic rel(input logic w, input logic [31:0] x);
    @(posedge clk);
    if (w) halt <= 1'b1;
    else nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    halt <= 1'b0;
    @(posedge clk);
    #1 chk("lockup", x, {31'h0, lock});
  endtask
  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    tab[0] = {19'h00001, 4'h2, 8'h04, 2'h1, 1'b1}; tab[1] = {19'h00002, 4'h0, 8'h01, 2'h3, 1'b1};
    tab[2] = {19'h00004, 4'h2, 8'h28, 2'h1, 1'b1}; tab[3] = {19'h0000C, 4'h2, 8'h10, 2'h1, 1'b1};
    tab[4] = {19'h00010, 4'h2, 8'h01, 2'h1, 1'b1}; tab[5] = {19'h00020, 4'h2, 8'h02, 2'h1, 1'b1};
    tab[6] = {19'h00040, 4'h1, 8'h01, 2'h0, 1'b1}; tab[7] = {19'h00080, 4'h1, 8'h01, 2'h0, 1'b1};
    tab[8] = {19'h00100, 4'h1, 8'h12, 2'h0, 1'b1}; tab[9] = {19'h00200, 4'h1, 8'h04, 2'h0, 1'b1};
    tab[10] = {19'h00400, 4'h1, 8'h08, 2'h0, 1'b1}; tab[11] = {19'h00800, 4'h3, 8'h01, 2'h2, 1'b1};
    tab[12] = {19'h01000, 4'h3, 8'h02, 2'h2, 1'b1}; tab[13] = {19'h02000, 4'h3, 8'h04, 2'h2, 1'b1};
    tab[14] = {19'h0C000, 4'h3, 8'h04, 2'h2, 1'b1}; tab[15] = {19'h04000, 4'h3, 8'h00, 2'h2, 1'b0};
    tab[16] = {19'h10000, 4'h3, 8'h08, 2'h2, 1'b1}; tab[17] = {19'h20000, 4'h3, 8'h10, 2'h2, 1'b1};
    tab[18] = {19'h40000, 4'h3, 8'h20, 2'h2, 1'b1};
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdc(`PFHU_ADDR_PRIO_CFG, {8'h00, `PFHU_PRIO_RESET});
    rdc(`PFHU_ADDR_ENABLE_CTRL, {29'h0, `PFHU_ENABLE_RESET});
    wr(4'hF, 32'hFFFFFFFF);
    rdc(4'hF, 32'h0);
    wr(`PFHU_ADDR_PRIO_CFG, 32'h00302010);
    rdc(`PFHU_ADDR_PRIO_CFG, 32'h00302010);
    wr(`PFHU_ADDR_ENABLE_CTRL, 32'h00000007);
    for (i = 5'h0; i < 5'd19; i++) begin
      {e, ix, v, c, t} = tab[i];
      fire(e, 32'hA0000000 + {27'h0, i});
      chk("take", {31'h0, t}, {31'h0, t_take});
      if (t) chk("class", {30'h0, c}, {30'h0, t_cls});
      rdc(ix, {24'h0, v});
      if (ix == 4'h2 && v[5]) rdc(`PFHU_ADDR_BUS_ADDR, 32'hA0000000 + {27'h0, i});
      if (ix == 4'h1 && v[4]) rdc(`PFHU_ADDR_PROT_ADDR, 32'hA0000000 + {27'h0, i});
      wr(ix, 32'hFFFFFFFF);
      rdc(ix, 32'h0);
    end
    wr(`PFHU_ADDR_ENABLE_CTRL, 32'h00000003);
    esc(5'h00, 8'h00, 2'h0, 19'h01000, 2'h3, 32'h2);
    wr(`PFHU_ADDR_ENABLE_CTRL, 32'h00000007);
    esc(5'h18, 8'hFF, 2'h2, 19'h01000, 2'h3, 32'h2);
    esc(5'h10, 8'h30, 2'h0, 19'h01000, 2'h3, 32'h2);
    esc(5'h10, 8'h20, 2'h0, 19'h01000, 2'h3, 32'h2);
    esc(5'h10, 8'h40, 2'h0, 19'h01000, 2'h2, 32'h0);
    esc(5'h19, 8'h10, 2'h1, 19'h00010, 2'h1, 32'h0);
    esc(5'h10, 8'h00, 2'h0, 19'h00002, 2'h3, 32'h1);
    lock_in(5'h1A, 32'h1);
    fire(19'h01000, 32'h0);
    chk("take", 32'h0, {31'h0, t_take});
    rel(1'b0, 32'h0);
    lock_in(5'h14, 32'h2);
    rel(1'b0, 32'h1);
    rel(1'b1, 32'h0);
    lock_in(5'h1A, 32'h1);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk("lockup", 32'h0, {31'h0, lock});
    final_report();
  end
endmodule // pfhu_fault_unit_bench
